// ### dtb_trigger_unit.sv
// Summary of operation
// - Force break holds request until core finishes instruction and enters background mode.
// - Tag break marks fetched opcode; core substitutes halt opcode if it executes.
// - In all but the two range modes, opcode qualification triggers only when the matched opcode actually executes.
// - Each comparator owns an independent opcode tracker.
// - Four-bit mode field selects one of nine trigger modes for the run.
// - Begin select chooses store-after-trigger or circular store until trigger.
// - Writing run one arms, clears word count and loads hit flags with that cycle's match.
// - Begin run ends on full buffer; end run ends on trigger.
// - Writing zero to run or enable stops the run at once.
// - Address modes store change-of-flow addresses.
// - Event-only modes store the data byte in the low bits.
// - Event-only modes ignore begin select and always run begin type.
// - Comparators optionally qualify on bus direction.
// - Break enable raises break request; kind bit picks tag or force.
// - A-only mode triggers on address equal to comparator A.
// - A-or-B mode triggers on address equal to A or B.
// - Without halt permission the substitute opcode is software interrupt.
// - Run bit clears itself when the run completes.
// - Enable cannot be set while the device is secure.
// - Break at full for begin runs, at trigger for end runs.
// - Direction value zero means write, one means read.
`timescale 1ns/1ps
`default_nettype none
`include "dtb_consts.svh"
module dtb_trigger_unit
    import dtb_pkg::*;
#(
    parameter int DEPTH = `DTB_FIFO_DEPTH,
    parameter logic [7:0] HALT_OPCODE = `DTB_HALT_OPCODE,
    parameter logic [7:0] SWI_OPCODE = `DTB_SWI_OPCODE,
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1,
    localparam int CW = $clog2(DEPTH + 1)
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Control write
    input wire logic ctrl_wr,
    input wire logic ctrl_monitor_enable,
    input wire logic ctrl_run,
    input wire logic ctrl_break_tag_kind,
    input wire logic ctrl_break_request_enable,
    input wire logic ctrl_compare_a_dir_value,
    input wire logic ctrl_compare_a_dir_qualify,
    input wire logic ctrl_compare_b_dir_value,
    input wire logic ctrl_compare_b_dir_qualify,
    // Trigger setup
    input wire logic [3:0] trigger_mode_field,
    input wire logic opcode_qualify_select,
    input wire logic trace_begin_select,
    input wire logic [15:0] comp_a_value,
    input wire logic [15:0] comp_b_value,
    // Device state
    input wire logic secure_state,
    input wire logic debug_halt_allow,
    // Observed bus
    input wire logic bus_valid,
    input wire logic bus_rd,
    input wire logic [15:0] bus_addr,
    input wire logic [7:0] bus_data,
    input wire logic opcode_fetch,
    input wire logic cof_valid,
    input wire logic [15:0] cof_addr,
    // Core pipeline
    input wire logic exec_valid,
    input wire logic [15:0] exec_addr,
    input wire logic queue_flush,
    input wire logic core_break_ack,
    // Trace readout
    input wire logic fifo_rd,
    output logic [15:0] fifo_rd_data,
    // Status
    output logic monitor_enable,
    output logic run_active_flag,
    output logic comparator_a_hit_flag,
    output logic comparator_b_hit_flag,
    output logic [CW-1:0] fifo_word_count,
    // Break requests
    output logic break_force_req,
    output logic break_tag_mark,
    output logic [7:0] break_opcode
);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    typedef struct packed {
        dtb_run_t st;
        logic en;
        logic run;
        logic tag_kind;
        logic brk_en;
        logic compare_a_dir_value;
        logic compare_a_dir_qualify;
        logic compare_b_dir_value;
        logic compare_b_dir_qualify;
        logic a_hit;
        logic b_hit;
        logic a_seen;
        logic [CW-1:0] cnt;
        logic [PW-1:0] wptr;
        logic [DEPTH-1:0][15:0] mem;
        logic [15:0] rd_data;
        logic brk_force;
        logic brk_tag;
        logic [7:0] brk_op;
    } dtb_st_t;

    dtb_st_t q, d;
    logic raw_a, raw_b, qa, qb, trig, ev, beg, store_now, brk_evt, start, stop;
    logic trk_a_hit, trk_b_hit;
    logic [15:0] word;

    function automatic logic is_event(input logic [3:0] m);
        return (m == `DTB_MODE_EVENT_B) || (m == `DTB_MODE_A_THEN_EVENT_B);
    endfunction

    function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
        return (int'(p) == DEPTH - 1) ? '0 : PW'(int'(p) + 1);
    endfunction

    function automatic logic [PW-1:0] ptr_back(input logic [PW-1:0] p, input logic [CW-1:0] n);
        return (int'(p) >= int'(n)) ? PW'(int'(p) - int'(n)) : PW'(int'(p) + DEPTH - int'(n));
    endfunction

    function automatic logic dir_ok(input logic qual, input logic val, input logic rd);
        return !qual || (rd == val);
    endfunction

    // Raw comparator matches
    assign raw_a = bus_valid && bus_addr == comp_a_value && dir_ok(q.compare_a_dir_qualify, q.compare_a_dir_value, bus_rd);
    assign raw_b = bus_valid && bus_addr == comp_b_value && dir_ok(q.compare_b_dir_qualify, q.compare_b_dir_value, bus_rd);

    // One tracker per comparator so pending compares do not collide
    dtb_opcode_tracker u_trk_a (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clear(q.st == DTB_IDLE),
        .fetch_match(raw_a && opcode_fetch),
        .fetch_addr(bus_addr),
        .exec_valid(exec_valid),
        .exec_addr(exec_addr),
        .queue_flush(queue_flush),
        .exec_hit(trk_a_hit)
    );
    dtb_opcode_tracker u_trk_b (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clear(q.st == DTB_IDLE),
        .fetch_match(raw_b && opcode_fetch),
        .fetch_addr(bus_addr),
        .exec_valid(exec_valid),
        .exec_addr(exec_addr),
        .queue_flush(queue_flush),
        .exec_hit(trk_b_hit)
    );

    assign qa = opcode_qualify_select ? trk_a_hit : raw_a;
    assign qb = opcode_qualify_select ? trk_b_hit : raw_b;

    always_comb begin
        trig = 1'b0;
        unique case (trigger_mode_field)
            `DTB_MODE_A_ONLY: trig = qa;
            `DTB_MODE_A_OR_B: trig = qa || qb;
            `DTB_MODE_A_THEN_B: trig = q.a_seen && qb;
            `DTB_MODE_EVENT_B: trig = qb;
            `DTB_MODE_A_THEN_EVENT_B: trig = q.a_seen && qb;
            `DTB_MODE_A_AND_B_DATA: trig = qa && bus_data == comp_b_value[7:0];
            `DTB_MODE_A_NOT_B_DATA: trig = qa && bus_data != comp_b_value[7:0];
            `DTB_MODE_INSIDE: trig = bus_valid && bus_addr >= comp_a_value
                && bus_addr <= comp_b_value;
            `DTB_MODE_OUTSIDE: trig = bus_valid && (bus_addr < comp_a_value
                || bus_addr > comp_b_value);
            default: trig = 1'b0;
        endcase
    end

    always_comb begin
        d = q;
        d.brk_tag = 1'b0;
        brk_evt = 1'b0;
        ev = is_event(trigger_mode_field);
        beg = ev || trace_begin_select;
        if (ev) begin
            store_now = trig && q.st != DTB_IDLE;
            word = {8'h00, bus_data};
        end else begin
            store_now = cof_valid && (q.st == DTB_STORE || (q.st == DTB_WAIT && !beg));
            word = cof_addr;
        end
        if (ctrl_wr) begin
            d.en = ctrl_monitor_enable && (q.en || !secure_state);
            d.tag_kind = ctrl_break_tag_kind;
            d.brk_en = ctrl_break_request_enable;
            d.compare_a_dir_value = ctrl_compare_a_dir_value;
            d.compare_a_dir_qualify = ctrl_compare_a_dir_qualify;
            d.compare_b_dir_value = ctrl_compare_b_dir_value;
            d.compare_b_dir_qualify = ctrl_compare_b_dir_qualify;
        end
        start = ctrl_wr && ctrl_run && d.en;
        stop = ctrl_wr && !start;
        if (start) begin
            d.st = DTB_WAIT;
            d.run = 1'b1;
            d.cnt = '0;
            d.a_seen = 1'b0;
            // Match in the arming cycle still counts
            d.a_hit = qa;
            d.b_hit = qb;
        end else if (stop) begin
            d.st = DTB_IDLE;
            d.run = 1'b0;
        end else if (q.st != DTB_IDLE) begin
            if (qa) begin
                d.a_hit = 1'b1;
                d.a_seen = 1'b1;
            end
            if (qb) begin
                d.b_hit = 1'b1;
            end
            if (store_now) begin
                d.mem[q.wptr] = word;
                d.wptr = ptr_next(q.wptr);
                // Circular store keeps the newest words once full
                if (q.cnt != FULL) begin
                    d.cnt = q.cnt + CW'(1);
                end
            end
            unique case (q.st)
                DTB_WAIT: begin
                    if (trig && beg) begin
                        d.st = DTB_STORE;
                    end else if (trig) begin
                        d.st = DTB_IDLE;
                        d.run = 1'b0;
                        brk_evt = 1'b1;
                    end
                end
                DTB_STORE: ;
                default: d.st = DTB_IDLE;
            endcase
            if (beg && store_now && q.cnt == FULL - CW'(1)) begin
                d.st = DTB_IDLE;
                d.run = 1'b0;
                brk_evt = 1'b1;
            end
        end else if (fifo_rd && q.cnt != '0) begin
            d.rd_data = q.mem[ptr_back(q.wptr, q.cnt)];
            d.cnt = q.cnt - CW'(1);
        end
        if (core_break_ack) begin
            d.brk_force = 1'b0;
        end
        if (brk_evt && q.brk_en) begin
            if (q.tag_kind) begin
                d.brk_tag = 1'b1;
            end else begin
                d.brk_force = 1'b1;
            end
            d.brk_op = debug_halt_allow ? HALT_OPCODE : SWI_OPCODE;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign fifo_rd_data = q.rd_data;
    assign monitor_enable = q.en;
    assign run_active_flag = q.run;
    assign comparator_a_hit_flag = q.a_hit;
    assign comparator_b_hit_flag = q.b_hit;
    assign fifo_word_count = q.cnt;
    assign break_force_req = q.brk_force;
    assign break_tag_mark = q.brk_tag;
    assign break_opcode = q.brk_op;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_start;
        ctrl_wr && ctrl_run && ctrl_monitor_enable && !secure_state
            |=> run_active_flag && fifo_word_count == '0;
    endproperty
    a_start: assert property (p_start) else $error("arming did not start run");

    property p_stop;
        ctrl_wr && (!ctrl_run || !ctrl_monitor_enable) |=> !run_active_flag;
    endproperty
    a_stop: assert property (p_stop) else $error("run not stopped");

    property p_secure;
        ctrl_wr && secure_state && !monitor_enable |=> !monitor_enable;
    endproperty
    a_secure: assert property (p_secure) else $error("enable set while secure");

    property p_full_end;
        beg && store_now && q.cnt == FULL - CW'(1) && !ctrl_wr
            |=> !run_active_flag && fifo_word_count == FULL;
    endproperty
    a_full_end: assert property (p_full_end) else $error("begin run not ended at full");

    property p_trig_end;
        q.st == DTB_WAIT && trig && !beg && !ctrl_wr |=> !run_active_flag;
    endproperty
    a_trig_end: assert property (p_trig_end) else $error("end run not ended on trigger");

    property p_event_begin;
        q.st == DTB_WAIT && trig && ev && !ctrl_wr && q.cnt < FULL - CW'(1)
            |=> run_active_flag && q.st == DTB_STORE;
    endproperty
    a_event_begin: assert property (p_event_begin) else $error("event run not begin type");

    property p_force_hold;
        break_force_req && !core_break_ack |=> break_force_req;
    endproperty
    a_force_hold: assert property (p_force_hold) else $error("force request dropped early");

    property p_break_kind;
        brk_evt && q.brk_en |=> (break_tag_mark == $past(q.tag_kind)) && break_force_req
            == ($past(!q.tag_kind) || $past(q.brk_force && !core_break_ack));
    endproperty
    a_break_kind: assert property (p_break_kind) else $error("wrong break kind");

    property p_opcode_sel;
        $rose(break_tag_mark) || $rose(break_force_req)
            |-> break_opcode == ($past(debug_halt_allow) ? HALT_OPCODE : SWI_OPCODE);
    endproperty
    a_opcode_sel: assert property (p_opcode_sel) else $error("wrong substitute opcode");

    property p_a_only;
        q.st == DTB_WAIT && !ctrl_wr && trigger_mode_field == `DTB_MODE_A_ONLY && qa
            && !trace_begin_select |=> !run_active_flag;
    endproperty
    a_a_only: assert property (p_a_only) else $error("A-only match missed");

    c_begin_full: cover property (beg && !ev && store_now && q.cnt == FULL - CW'(1));
    c_end_trig: cover property (q.st == DTB_WAIT && trig && !beg);
    c_tag_break: cover property (break_tag_mark);
    c_force_ack: cover property (break_force_req ##1 core_break_ack);
endmodule // dtb_trigger_unit
`default_nettype wire

// ### dtb_consts.svh
`ifndef DTB_CONSTS_SVH
`define DTB_CONSTS_SVH

// Trace buffer depth and address width
`define DTB_FIFO_DEPTH 8
`define DTB_ADDR_W 16

// Trigger mode encodings
`define DTB_MODE_A_ONLY 4'h0
`define DTB_MODE_A_OR_B 4'h1
`define DTB_MODE_A_THEN_B 4'h2
`define DTB_MODE_EVENT_B 4'h3
`define DTB_MODE_A_THEN_EVENT_B 4'h4
`define DTB_MODE_A_AND_B_DATA 4'h5
`define DTB_MODE_A_NOT_B_DATA 4'h6
`define DTB_MODE_INSIDE 4'h7
`define DTB_MODE_OUTSIDE 4'h8

// Replacement opcodes handed to the core (arbitrary values)
`define DTB_HALT_OPCODE 8'hA5
`define DTB_SWI_OPCODE 8'h5A

// Reset values
`define DTB_RST_BIT 1'b0
`define DTB_RST_BYTE 8'h00
`define DTB_RST_WORD 16'h0000

`endif

// ### dtb_pkg.sv
`default_nettype none
package dtb_pkg;
    typedef enum logic [1:0] {
        DTB_IDLE = 2'b00,
        DTB_WAIT = 2'b01,
        DTB_STORE = 2'b11
    } dtb_run_t;

    typedef struct packed {
        logic pend;
        logic [15:0] addr;
        logic hit;
    } dtb_trk_t;
endpackage
`default_nettype wire

// ### dtb_opcode_tracker.sv
`timescale 1ns/1ps
`default_nettype none
`include "dtb_consts.svh"
module dtb_opcode_tracker
    import dtb_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Control
    input wire logic clear,
    // Opcode fetch side
    input wire logic fetch_match,
    input wire logic [15:0] fetch_addr,
    // Execution side
    input wire logic exec_valid,
    input wire logic [15:0] exec_addr,
    input wire logic queue_flush,
    // Result
    output logic exec_hit
);
    dtb_trk_t q, d;

    always_comb begin
        d = q;
        d.hit = 1'b0;
        if (q.pend && exec_valid && exec_addr == q.addr) begin
            d.hit = 1'b1;
            d.pend = 1'b0;
        end
        if (queue_flush || clear) begin
            d.pend = 1'b0;
        end
        // New fetch wins over flush
        if (fetch_match && !clear) begin
            d.pend = 1'b1;
            d.addr = fetch_addr;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign exec_hit = q.hit;

    property p_trk_hit;
        @(posedge core_clk) disable iff (!rst_n)
        q.hit |-> $past(q.pend) && $past(exec_valid) && ($past(exec_addr) == $past(q.addr));
    endproperty
    a_trk_hit: assert property (p_trk_hit) else $error("tracker hit without executed opcode");
endmodule // dtb_opcode_tracker
`default_nettype wire

// ### dtb_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module dtb_core_model #(
    parameter int ACK_DLY = 3,
    parameter int EXEC_DLY = 3
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Break request from the trace unit
    input wire logic break_force_req,
    // Opcode fetches seen on the bus
    input wire logic fetch,
    input wire logic [15:0] fetch_addr,
    input wire logic flush,
    // Answers to the trace unit
    output logic core_break_ack,
    output logic exec_valid,
    output logic [15:0] exec_addr
);
    int ack_cnt;
    int exe_cnt;
    logic pend;

    // Ack only once the instruction in flight has had time to finish
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_cnt <= 0;
            core_break_ack <= 1'b0;
        end else begin
            core_break_ack <= break_force_req && !core_break_ack && ack_cnt == ACK_DLY;
            ack_cnt <= (break_force_req && ack_cnt < ACK_DLY) ? ack_cnt + 1 : 0;
        end
    end

    // One-deep queue; a newer fetch replaces the older one
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend <= 1'b0;
            exe_cnt <= 0;
            exec_valid <= 1'b0;
            exec_addr <= 16'h0000;
        end else begin
            exec_valid <= pend && !flush && exe_cnt == EXEC_DLY - 1;
            if (fetch) begin
                pend <= 1'b1;
                exe_cnt <= 0;
                exec_addr <= fetch_addr;
            end else if (flush || exe_cnt == EXEC_DLY - 1) begin
                pend <= 1'b0;
            end else begin
                exe_cnt <= exe_cnt + 1;
            end
        end
    end
endmodule // dtb_core_model
`default_nettype wire

// ### dtb_trigger_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dtb_consts.svh"
module dtb_trigger_unit_tb;
    localparam int DEPTH = 4;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [15:0] CA = 16'h1234;
    localparam logic [15:0] CB = 16'h5678;
    logic core_clk, rst_n, ctrl_wr, opcode_qualify_select, trace_begin_select;
    logic secure_state, debug_halt_allow, bus_valid, bus_rd, opcode_fetch;
    logic cof_valid, queue_flush, fifo_rd, exec_valid, core_break_ack;
    logic monitor_enable, run_active_flag, comparator_a_hit_flag, comparator_b_hit_flag;
    logic break_force_req, break_tag_mark;
    logic [7:0] ctrl, bus_data, break_opcode;
    logic [3:0] trigger_mode_field;
    logic [15:0] bus_addr, cof_addr, exec_addr, fifo_rd_data;
    logic [15:0] comp_a_value = CA;
    logic [15:0] comp_b_value = CB;
    logic [CW-1:0] fifo_word_count;
    int n_errors = 0;
    int n_tests = 0;
    int n_tag = 0;

    dtb_trigger_unit #(.DEPTH(DEPTH)) u_dtb_trigger_unit (
        .ctrl_monitor_enable(ctrl[7]), .ctrl_run(ctrl[6]), .ctrl_break_tag_kind(ctrl[5]),
        .ctrl_break_request_enable(ctrl[4]), .ctrl_compare_a_dir_value(ctrl[3]),
        .ctrl_compare_a_dir_qualify(ctrl[2]), .ctrl_compare_b_dir_value(ctrl[1]),
        .ctrl_compare_b_dir_qualify(ctrl[0]), .*
    );

    dtb_core_model #(.ACK_DLY(3), .EXEC_DLY(3)) u_dtb_core_model (
        .core_clk(core_clk), .rst_n(rst_n), .break_force_req(break_force_req),
        .fetch(bus_valid & opcode_fetch), .fetch_addr(bus_addr), .flush(queue_flush),
        .core_break_ack(core_break_ack), .exec_valid(exec_valid), .exec_addr(exec_addr)
    );

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Tag marks are single-cycle pulses, so count them here
    always @(posedge core_clk) n_tag <= n_tag + int'(break_tag_mark === 1'b1);

    task automatic wrap_up();
        if (n_errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cfg(input logic [3:0] m, input logic [3:0] f);
        @(posedge core_clk);
        trigger_mode_field <= m;
        {opcode_qualify_select, trace_begin_select, secure_state, debug_halt_allow} <= f;
        @(negedge core_clk);
    endtask

    task automatic wr(input logic [7:0] c);
        @(posedge core_clk);
        ctrl <= c;
        ctrl_wr <= 1'b1;
        @(posedge core_clk);
        ctrl_wr <= 1'b0;
        @(negedge core_clk);
    endtask

    task automatic bus(input logic rd, input logic [15:0] a, input logic [7:0] d, input logic f);
        @(posedge core_clk);
        {bus_valid, bus_rd, bus_addr, bus_data, opcode_fetch} <= {1'b1, rd, a, d, f};
        @(posedge core_clk);
        {bus_valid, opcode_fetch} <= 2'b00;
        bus_addr <= ~a;
        @(negedge core_clk);
    endtask

    // Kind 0 stores a flow address, 1 flushes the queue, 2 pops and compares
    task automatic pulse(input int k, input logic [15:0] a);
        @(posedge core_clk);
        cof_valid <= (k == 0);
        cof_addr <= a;
        queue_flush <= (k == 1);
        fifo_rd <= (k == 2);
        @(posedge core_clk);
        {cof_valid, queue_flush, fifo_rd} <= 3'b000;
        cof_addr <= ~a;
        @(negedge core_clk);
        if (k == 2)
            chk(fifo_rd_data, a);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    // Waits for the run flag (0) or the force request (1) to drop
    task automatic wait_lo(input int w);
        int i;
        for (i = 0; i < 20; i++) begin
            if ((w == 0 ? run_active_flag : break_force_req) === 1'b0)
                break;
            @(negedge core_clk);
        end
        if (i == 20) begin
            chk(16'h0001, 16'h0000);
            wrap_up();
        end
    endtask

    // Miss, then a priming cycle, then the hit that ends an end-type run
    task automatic mode_run(input logic [3:0] m, input logic [15:0] ma, input logic [7:0] md,
        input logic [15:0] pa, input logic [15:0] ha, input logic [7:0] hd);
        cfg(m, 4'b0000);
        wr(8'hC0);
        bus(1'b0, ma, md, 1'b0);
        idle(1);
        chk(16'(run_active_flag), 16'h0001);
        bus(1'b0, pa, md, 1'b0);
        bus(1'b0, ha, hd, 1'b0);
        wait_lo(0);
        chk(16'(run_active_flag), 16'h0000);
    endtask

    initial begin
        {ctrl_wr, fifo_rd, bus_valid, bus_rd, opcode_fetch, cof_valid, queue_flush} = 7'h00;
        {opcode_qualify_select, trace_begin_select, secure_state, debug_halt_allow} = 4'h0;
        {ctrl, bus_data, trigger_mode_field, bus_addr, cof_addr} = 52'h0;
        rst_n = 1'b0;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        chk(16'({fifo_word_count, run_active_flag, monitor_enable}), 16'h0000);
        chk(16'({comparator_a_hit_flag, comparator_b_hit_flag}), 16'h0000);
        chk(16'({break_opcode, break_force_req, break_tag_mark}), 16'h0000);
        cfg(4'h0, 4'b0010);
        wr(8'hD0);
        chk(16'({monitor_enable, run_active_flag}), 16'h0000);
        // End trace, circular store, force break
        cfg(4'h0, 4'b0000);
        wr(8'hD0);
        chk(16'({monitor_enable, run_active_flag}), 16'h0003);
        chk(16'(fifo_word_count), 16'h0000);
        for (int i = 1; i < 6; i++)
            pulse(0, 16'(i * 256));
        chk(16'(fifo_word_count), 16'(DEPTH));
        bus(1'b0, CA, 8'h00, 1'b0);
        wait_lo(0);
        chk(16'({comparator_a_hit_flag, comparator_b_hit_flag, break_force_req}), 16'h0005);
        chk(16'(break_opcode), 16'(`DTB_SWI_OPCODE));
        wait_lo(1);
        for (int i = 2; i < 6; i++)
            pulse(2, 16'(i * 256));
        // Either comparator, tag break
        cfg(4'h1, 4'b0001);
        wr(8'hF0);
        bus(1'b1, CB, 8'h00, 1'b0);
        wait_lo(0);
        idle(1);
        chk(16'({comparator_a_hit_flag, comparator_b_hit_flag, break_force_req}), 16'h0002);
        chk(16'(n_tag), 16'h0001);
        chk(16'(break_opcode), 16'(`DTB_HALT_OPCODE));
        // Wrong direction first, then the matching one
        cfg(4'h0, 4'b0000);
        for (int v = 0; v < 2; v++) begin
            wr({4'hC, v[0], 3'b100});
            bus(!v[0], CA, 8'h00, 1'b0);
            idle(2);
            chk(16'({run_active_flag, comparator_a_hit_flag}), 16'h0002);
            bus(v[0], CA, 8'h00, 1'b0);
            wait_lo(0);
            chk(16'(comparator_a_hit_flag), 16'h0001);
        end
        wr(8'hC0);
        wr(8'h40);
        chk(16'({monitor_enable, run_active_flag}), 16'h0000);
        wr(8'hC0);
        wr(8'h80);
        chk(16'({monitor_enable, run_active_flag}), 16'h0002);
        // Begin trace ignores flow before the trigger
        cfg(4'h0, 4'b0100);
        wr(8'hD0);
        pulse(0, 16'h0AAA);
        chk(16'(fifo_word_count), 16'h0000);
        bus(1'b0, CA, 8'h00, 1'b0);
        for (int i = 0; i < DEPTH; i++)
            pulse(0, 16'(16'h0B00 + i));
        wait_lo(0);
        chk(16'({fifo_word_count, break_force_req}), 16'({CW'(DEPTH), 1'b1}));
        wait_lo(1);
        for (int i = 0; i < DEPTH; i++)
            pulse(2, 16'(16'h0B00 + i));
        // Event mode with end select still runs to full
        cfg(4'h3, 4'b0000);
        wr(8'hC0);
        for (int i = 1; i <= DEPTH; i++)
            bus(1'b0, CB, 8'(i * 17), 1'b0);
        wait_lo(0);
        chk(16'(fifo_word_count), 16'(DEPTH));
        for (int i = 1; i <= DEPTH; i++)
            pulse(2, 16'(i * 17));
        // A then event B stores only events after A
        cfg(`DTB_MODE_A_THEN_EVENT_B, 4'b0000);
        wr(8'hC0);
        bus(1'b0, CB, 8'h22, 1'b0);
        chk(16'(fifo_word_count), 16'h0000);
        bus(1'b0, CA, 8'h00, 1'b0);
        bus(1'b0, CB, 8'h33, 1'b0);
        chk(16'(fifo_word_count), 16'h0001);
        wr(8'h80);
        pulse(2, 16'h0033);
        // Remaining end-type modes
        mode_run(`DTB_MODE_A_THEN_B, CB, 8'h00, CA, CB, 8'h00);
        mode_run(`DTB_MODE_A_AND_B_DATA, CA, 8'h77, CA, CA, 8'h78);
        mode_run(`DTB_MODE_A_NOT_B_DATA, CA, 8'h78, CA, CA, 8'h77);
        mode_run(`DTB_MODE_INSIDE, 16'h0100, 8'h00, 16'h0100, 16'h3000, 8'h00);
        mode_run(`DTB_MODE_OUTSIDE, 16'h3000, 8'h00, 16'h3000, 16'h0100, 8'h00);
        // Opcode qualified: fetch alone must not trigger
        cfg(4'h0, 4'b1000);
        wr(8'hC0);
        bus(1'b1, CA, 8'h00, 1'b1);
        idle(1);
        chk(16'({run_active_flag, comparator_a_hit_flag}), 16'h0002);
        wait_lo(0);
        chk(16'(comparator_a_hit_flag), 16'h0001);
        wr(8'hC0);
        bus(1'b1, CA, 8'h00, 1'b1);
        pulse(1, 16'h0000);
        idle(6);
        chk(16'({run_active_flag, comparator_a_hit_flag}), 16'h0002);
        wr(8'h80);
        wrap_up();
    end
endmodule // dtb_trigger_unit_tb
`default_nettype wire
